// file: wsb_store_unit.sv
// word store execution and completion barrier
`timescale 1ns/1ps
`default_nettype none
`include "wsb_regs.svh"
module wsb_store_unit #(
	parameter int ADDR_W = 32,
	parameter int CNT_W  = 8
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             op_valid,
	output logic                  op_ready,
	input  wire wsb_pkg::wsb_op_e op_kind,
	input  wire logic [31:0]      base_value,
	input  wire logic [15:0]      displacement,
	input  wire logic [31:0]      source_value,
	input  wire logic [4:0]       barrier_type,
	input  wire logic             release6,
	input  wire logic             kernel_mode,
	input  wire logic             segment_mode_ok,
	input  wire logic             enhanced_addressing_flag,
	input  wire logic [1:0]       global_invalidate_support_field,
	input  wire logic             cop_usable,
	input  wire logic             float_present,
	input  wire logic             cop_two_present,
	input  wire logic             misalign_support,
	output logic                  xlat_req,
	output logic [31:0]           xlat_vaddr,
	output logic                  xlat_user_map,
	input  wire logic             xlat_done,
	input  wire logic [31:0]      xlat_paddr,
	input  wire logic [2:0]       xlat_cca,
	input  wire logic             xlat_refill,
	input  wire logic             xlat_invalid,
	input  wire logic             xlat_modified,
	input  wire logic             xlat_watch,
	input  wire logic             xlat_bus_err,
	output logic                  mem_wr_valid,
	input  wire logic             mem_wr_ready,
	output logic [31:0]           mem_wr_addr,
	output logic [31:0]           mem_wr_data,
	output logic [3:0]            mem_wr_be,
	output logic                  mem_wr_sync,
	input  wire logic             mem_wr_visible,
	input  wire logic             load_pending,
	input  wire logic             ginv_pending,
	output logic                  barrier_busy,
	output logic                  exc_valid,
	output wsb_pkg::wsb_exc_e     exc_code
);
	import wsb_pkg::*;

	// the counter must hold at least a few stores in flight
	if (ADDR_W != 32 || CNT_W < 2) begin : g_param_check
		$error("wsb_store_unit: unsupported parameters");
	end

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] sext_disp(input wsb_op_e k, input logic r6,
			input logic [15:0] d);
		logic [31:0] v;
		v = {{16{d[`WSB_IMM16_SIGN]}}, d};
		if (k == WSB_OP_USER)
			v = {{23{d[`WSB_IMM9_SIGN]}}, d[`WSB_IMM9_SIGN:0]};
		else if (k == WSB_OP_COPROCESSOR_TWO && r6)
			v = {{21{d[`WSB_IMM11_SIGN]}}, d[`WSB_IMM11_SIGN:0]};
		return v;
	endfunction

	function automatic logic cca_ordered(input logic [2:0] c);
		return (c == `WSB_CCA_UNCACHED) || (c == `WSB_CCA_COHERENT);
	endfunction

	// ------------------------------------------------------------
	// issue checks
	// ------------------------------------------------------------
	logic [31:0] ea;
	logic        is_store;
	wsb_exc_e    pre_exc;
	logic        misaligned;

	always_comb begin
		ea         = base_value + sext_disp(op_kind, release6, displacement);
		is_store   = op_valid && op_kind != WSB_OP_SYNC && op_kind != WSB_OP_NONE;
		misaligned = ea[`WSB_ALIGN_LO] != 2'h0;
		pre_exc    = WSB_EXC_NONE;
		case (op_kind)
			WSB_OP_USER: begin
				if (!enhanced_addressing_flag)
					pre_exc = WSB_EXC_RI;
				else if (!kernel_mode || !segment_mode_ok)
					pre_exc = WSB_EXC_CPU;
			end
			WSB_OP_FLOAT: begin
				if (!float_present)
					pre_exc = WSB_EXC_RI;
				else if (!cop_usable)
					pre_exc = WSB_EXC_CPU;
			end
			WSB_OP_COPROCESSOR_TWO: begin
				if (!cop_two_present)
					pre_exc = WSB_EXC_RI;
				else if (!cop_usable)
					pre_exc = WSB_EXC_CPU;
			end
			default: pre_exc = WSB_EXC_NONE;
		endcase
		// alignment after gating; release 6 may pass misaligned through
		if (pre_exc == WSB_EXC_NONE && misaligned && !(release6 && misalign_support))
			pre_exc = WSB_EXC_ADEL;
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	wsb_state_e  state_r;
	wsb_state_e  state_nxt;
	logic [31:0] data_r;
	logic [31:0] vaddr_r;
	logic        user_r;
	logic [CNT_W-1:0] out_cnt_r;
	logic        ginv_wait_r;
	logic        xlat_fault;
	wsb_exc_e    xlat_exc;

	always_comb begin
		xlat_fault = xlat_refill | xlat_invalid | xlat_modified | xlat_watch
			| (user_r & xlat_bus_err);
		xlat_exc = WSB_EXC_NONE;
		if (xlat_refill)
			xlat_exc = WSB_EXC_TLBREF;
		else if (xlat_invalid)
			xlat_exc = WSB_EXC_TLBINV;
		else if (xlat_modified)
			xlat_exc = WSB_EXC_TLBMOD;
		else if (xlat_watch)
			xlat_exc = WSB_EXC_WATCH;
		else if (user_r && xlat_bus_err)
			xlat_exc = WSB_EXC_BUS;
	end

	logic drain_done;
	assign drain_done = (out_cnt_r == '0) && !load_pending && !(ginv_wait_r && ginv_pending);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			WSB_ST_IDLE: begin
				if (op_valid && op_kind == WSB_OP_SYNC)
					state_nxt = WSB_ST_DRAIN;
				else if (is_store && pre_exc == WSB_EXC_NONE)
					state_nxt = WSB_ST_XLAT;
			end
			WSB_ST_XLAT: begin
				if (xlat_done)
					state_nxt = xlat_fault ? WSB_ST_IDLE : WSB_ST_WRITE;
			end
			WSB_ST_WRITE: begin
				if (mem_wr_ready)
					state_nxt = WSB_ST_IDLE;
			end
			WSB_ST_DRAIN: begin
				if (drain_done)
					state_nxt = WSB_ST_IDLE;
			end
			default: state_nxt = WSB_ST_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst)
			state_r <= WSB_ST_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			data_r  <= 32'h0;
			vaddr_r <= 32'h0;
			user_r  <= 1'b0;
		end else if (state_r == WSB_ST_IDLE && is_store) begin
			data_r  <= source_value;
			vaddr_r <= ea;
			user_r  <= op_kind == WSB_OP_USER;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			mem_wr_addr <= 32'h0;
			mem_wr_sync <= 1'b0;
		end else if (state_r == WSB_ST_XLAT && xlat_done) begin
			mem_wr_addr <= xlat_paddr;
			mem_wr_sync <= cca_ordered(xlat_cca);
		end
	end

	// stores to ordered memory still awaiting global visibility
	always_ff @(posedge clock) begin
		if (rst)
			out_cnt_r <= '0;
		else begin
			case ({state_r == WSB_ST_WRITE && mem_wr_ready && mem_wr_sync, mem_wr_visible})
				2'b10: out_cnt_r <= out_cnt_r + 1'b1;
				2'b01: out_cnt_r <= (out_cnt_r == '0) ? out_cnt_r : out_cnt_r - 1'b1;
				default: out_cnt_r <= out_cnt_r;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (rst)
			ginv_wait_r <= 1'b0;
		else if (state_r == WSB_ST_IDLE && op_valid && op_kind == WSB_OP_SYNC)
			ginv_wait_r <= release6 && barrier_type == `WSB_STYPE_GINV
				&& (global_invalidate_support_field == `WSB_GI_GLOBAL_A
				|| global_invalidate_support_field == `WSB_GI_GLOBAL_B);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			exc_valid <= 1'b0;
			exc_code  <= WSB_EXC_NONE;
		end else begin
			exc_valid <= 1'b0;
			exc_code  <= exc_code;
			if (state_r == WSB_ST_IDLE && is_store && pre_exc != WSB_EXC_NONE) begin
				exc_valid <= 1'b1;
				exc_code  <= pre_exc;
			end else if (state_r == WSB_ST_XLAT && xlat_done && xlat_fault) begin
				exc_valid <= 1'b1;
				exc_code  <= xlat_exc;
			end
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign op_ready      = state_r == WSB_ST_IDLE;
	assign xlat_req      = state_r == WSB_ST_XLAT;
	assign xlat_vaddr    = vaddr_r;
	assign xlat_user_map = user_r;
	assign mem_wr_valid  = state_r == WSB_ST_WRITE;
	assign mem_wr_data   = data_r;
	assign mem_wr_be     = `WSB_BYTE_EN_ALL;
	assign barrier_busy  = state_r == WSB_ST_DRAIN;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_sync_taken;
		op_ready && op_valid && op_kind == WSB_OP_SYNC;
	endsequence

	sequence s_no_write_two;
		!mem_wr_valid ##1 !mem_wr_valid;
	endsequence

	chk_align_error_raised: assert property (@(posedge clock) disable iff (rst)
		op_ready && is_store && misaligned && !release6 && op_kind == WSB_OP_WORD
		|=> exc_valid && exc_code == WSB_EXC_ADEL && !xlat_req)
		else $error("misaligned store not refused");

	chk_user_gate_flag: assert property (@(posedge clock) disable iff (rst)
		op_ready && op_valid && op_kind == WSB_OP_USER && !enhanced_addressing_flag
		|=> exc_valid && exc_code == WSB_EXC_RI)
		else $error("user store without flag not refused");

	chk_user_kernel_only: assert property (@(posedge clock) disable iff (rst)
		op_ready && op_valid && op_kind == WSB_OP_USER && enhanced_addressing_flag
		&& !kernel_mode |=> !xlat_req)
		else $error("user store outside kernel mode translated");

	chk_store_word_out: assert property (@(posedge clock) disable iff (rst)
		mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && mem_wr_be == `WSB_BYTE_EN_ALL
			&& $stable(mem_wr_addr) && $stable(mem_wr_data))
		else $error("store not a full word");

	chk_word_ea_form: assert property (@(posedge clock) disable iff (rst)
		op_ready && is_store && op_kind == WSB_OP_WORD && pre_exc == WSB_EXC_NONE
		|=> xlat_vaddr == $past(base_value)
			+ {{16{$past(displacement[15])}}, $past(displacement)})
		else $error("effective address wrong");

	chk_word_data_kept: assert property (@(posedge clock) disable iff (rst)
		op_ready && is_store && pre_exc == WSB_EXC_NONE
		|=> mem_wr_data == $past(source_value))
		else $error("store data not captured");

	chk_barrier_holds: assert property (@(posedge clock) disable iff (rst)
		barrier_busy && (out_cnt_r != '0 || load_pending) |=> barrier_busy && !op_ready)
		else $error("barrier released early");

	chk_word_exc_set: assert property (@(posedge clock) disable iff (rst)
		exc_valid && $past(op_kind) == WSB_OP_WORD && $past(op_ready)
		|-> exc_code != WSB_EXC_RI && exc_code != WSB_EXC_CPU && exc_code != WSB_EXC_BUS)
		else $error("word store raised foreign exception");

	chk_fault_no_write: assert property (@(posedge clock) disable iff (rst)
		xlat_req && xlat_done && xlat_fault |=> s_no_write_two)
		else $error("faulting store reached memory");

	chk_sync_busy: assert property (@(posedge clock) disable iff (rst)
		s_sync_taken |=> barrier_busy && !op_ready)
		else $error("barrier not entered");

	chk_drain_release: assert property (@(posedge clock) disable iff (rst)
		barrier_busy && drain_done |=> op_ready && !barrier_busy)
		else $error("barrier not released after drain");

	chk_ginv_hold: assert property (@(posedge clock) disable iff (rst)
		barrier_busy && ginv_wait_r && ginv_pending |=> barrier_busy)
		else $error("barrier ignored pending invalidates");

	chk_r6_misalign_pass: assert property (@(posedge clock) disable iff (rst)
		op_ready && op_valid && op_kind == WSB_OP_WORD && release6 && misalign_support
		|=> !exc_valid && xlat_req)
		else $error("supported misaligned store refused");

	chk_unordered_free: assert property (@(posedge clock) disable iff (rst)
		mem_wr_valid && mem_wr_ready && !mem_wr_sync && !mem_wr_visible
		|=> out_cnt_r == $past(out_cnt_r))
		else $error("unordered store counted by barrier");
endmodule
`default_nettype wire

// file: wsb_regs.svh
// constants for the word store and barrier block
`ifndef WSB_REGS_SVH
`define WSB_REGS_SVH
`define WSB_ALIGN_LO      1:0
`define WSB_IMM16_SIGN    15
`define WSB_IMM11_SIGN    10
`define WSB_IMM9_SIGN     8
`define WSB_GI_GLOBAL_A   2'h2
`define WSB_GI_GLOBAL_B   2'h3
`define WSB_STYPE_FULL    5'h00
`define WSB_STYPE_GINV    5'h14
`define WSB_BYTE_EN_ALL   4'hF
`define WSB_CCA_UNCACHED  3'h2
`define WSB_CCA_COHERENT  3'h5
`endif

// file: wsb_pkg.sv
// types for the word store and barrier block
`default_nettype none
package wsb_pkg;
	typedef enum logic [2:0] {
		WSB_OP_WORD  = 3'h0,
		WSB_OP_USER  = 3'h1,
		WSB_OP_FLOAT = 3'h2,
		WSB_OP_COPROCESSOR_TWO  = 3'h3,
		WSB_OP_SYNC  = 3'h4,
		WSB_OP_NONE  = 3'h7
	} wsb_op_e;
	typedef enum logic [3:0] {
		WSB_EXC_NONE   = 4'h0,
		WSB_EXC_ADEL   = 4'h1,
		WSB_EXC_TLBREF = 4'h2,
		WSB_EXC_TLBINV = 4'h3,
		WSB_EXC_TLBMOD = 4'h4,
		WSB_EXC_WATCH  = 4'h5,
		WSB_EXC_RI     = 4'h6,
		WSB_EXC_CPU    = 4'h7,
		WSB_EXC_BUS    = 4'h8
	} wsb_exc_e;
	typedef enum logic [3:0] {
		WSB_ST_IDLE  = 4'b0001,
		WSB_ST_XLAT  = 4'b0010,
		WSB_ST_WRITE = 4'b0100,
		WSB_ST_DRAIN = 4'b1000
	} wsb_state_e;
endpackage
`default_nettype wire

// file: wsb_mem_model.sv
// far-side model: address translation and shared memory
`timescale 1ns/1ps
`default_nettype none
module wsb_mem_model #(
	parameter logic [31:0] PA_OFS  = 32'h4000_0000,
	parameter int          VIS_DLY = 12
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        xlat_req,
	input  wire logic [31:0] xlat_vaddr,
	output logic             xlat_done,
	output logic [31:0]      xlat_paddr,
	output logic [2:0]       xlat_cca,
	output logic [4:0]       xlat_flt,
	input  wire logic        mem_wr_valid,
	output logic             mem_wr_ready,
	input  wire logic        mem_wr_sync,
	output logic             mem_wr_visible,
	input  wire logic [2:0]  cfg_cca,
	input  wire logic [4:0]  cfg_flt
);
	logic               dly_r;
	logic               rdy_r;
	logic [VIS_DLY-1:0] vis_r;
	// released answer lines show the inverse, never a stale value
	assign xlat_paddr = xlat_done ? xlat_vaddr + PA_OFS : ~(xlat_vaddr + PA_OFS);
	assign xlat_cca = xlat_done ? cfg_cca : ~cfg_cca;
	assign xlat_flt = xlat_done ? cfg_flt : ~cfg_flt;
	assign mem_wr_ready = rdy_r;
	assign mem_wr_visible = vis_r[VIS_DLY-1];
	// translation answers on the third cycle of a request
	always_ff @(posedge clock) begin
		dly_r <= !rst && xlat_req && !xlat_done;
		xlat_done <= !rst && xlat_req && dly_r && !xlat_done;
		rdy_r <= !rst && mem_wr_valid && !rdy_r;
	end
	// every ordered store gets its own visibility pulse, so none is lost
	always_ff @(posedge clock) begin
		if (rst) begin
			vis_r <= '0;
		end else begin
			vis_r <= {vis_r[VIS_DLY-2:0], mem_wr_valid && rdy_r && mem_wr_sync};
		end
	end
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the word store unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import wsb_pkg::*;
	localparam logic [31:0] PA_OFS = 32'h4000_0000;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic op_valid, op_ready, release6, kernel_mode, segment_mode_ok, cop_usable;
	logic enhanced_addressing_flag, float_present, cop_two_present, misalign_support;
	logic xlat_req, xlat_user_map, xlat_done, load_pending, ginv_pending, exc_valid;
	logic mem_wr_valid, mem_wr_ready, mem_wr_sync, mem_wr_visible, barrier_busy;
	wsb_op_e  op_kind;
	wsb_exc_e exc_code;
	logic [31:0] base_value, source_value, xlat_vaddr, xlat_paddr, mem_wr_addr, mem_wr_data;
	logic [15:0] displacement;
	logic [4:0]  barrier_type, xlat_flt, cfg_flt;
	logic [3:0]  mem_wr_be;
	logic [2:0]  xlat_cca, cfg_cca;
	logic [1:0]  global_invalidate_support_field;
	int mismatches = 0;
	int num_checks = 0;
	wsb_exc_e tlb_codes [4] = '{WSB_EXC_TLBREF, WSB_EXC_TLBINV, WSB_EXC_TLBMOD, WSB_EXC_WATCH};
	always #10 clock = ~clock;
	wsb_store_unit wsb_store_unit_inst (.clock, .rst, .op_valid, .op_ready, .op_kind,
		.base_value, .displacement, .source_value, .barrier_type, .release6, .kernel_mode,
		.segment_mode_ok, .enhanced_addressing_flag, .global_invalidate_support_field,
		.cop_usable, .float_present, .cop_two_present, .misalign_support, .xlat_req,
		.xlat_vaddr, .xlat_user_map, .xlat_done, .xlat_paddr, .xlat_cca,
		.xlat_refill(xlat_flt[0]), .xlat_invalid(xlat_flt[1]), .xlat_modified(xlat_flt[2]),
		.xlat_watch(xlat_flt[3]), .xlat_bus_err(xlat_flt[4]), .mem_wr_valid, .mem_wr_ready,
		.mem_wr_addr, .mem_wr_data, .mem_wr_be, .mem_wr_sync, .mem_wr_visible,
		.load_pending, .ginv_pending, .barrier_busy, .exc_valid, .exc_code);
	wsb_mem_model wsb_mem_model_inst (.clock, .rst, .xlat_req, .xlat_vaddr, .xlat_done,
		.xlat_paddr, .xlat_cca, .xlat_flt, .mem_wr_valid, .mem_wr_ready, .mem_wr_sync,
		.mem_wr_visible, .cfg_cca, .cfg_flt);
	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// every wait is bounded; a hang ends the run as a failure
	task automatic tick(inout int n);
		@(negedge clock);
		n++;
		if (n > 200) begin
			mismatches++;
			wrap_up();
		end
	endtask
	task automatic issue(input wsb_op_e k, input logic [31:0] b, input logic [15:0] d);
		int n;
		n = 0;
		// one idle edge between requests keeps each strobe change in its own step
		do tick(n); while (op_ready !== 1'b1);
		op_kind = k;
		base_value = b;
		displacement = d;
		op_valid = 1'b1;
		@(negedge clock);
		op_valid = 1'b0;
	endtask
	task automatic store(input wsb_op_e k, input logic [31:0] b, input logic [15:0] d,
			input logic [31:0] ea, input wsb_exc_e ex);
		int n;
		n = 0;
		source_value = b ^ 32'h5A5A_0F0F;
		issue(k, b, d);
		while (exc_valid !== 1'b1 && (mem_wr_valid & mem_wr_ready) !== 1'b1) tick(n);
		chk(32'(exc_valid), 32'(ex != WSB_EXC_NONE));
		if (ex != WSB_EXC_NONE) begin
			chk(32'(exc_code), 32'(ex));
		end else begin
			chk(xlat_vaddr, ea);
			chk(32'(xlat_user_map), 32'(k == WSB_OP_USER));
			chk(mem_wr_addr, ea + PA_OFS);
			chk(mem_wr_data, source_value);
			chk(32'(mem_wr_be), 32'h0000_000F);
			chk(32'(mem_wr_sync), 32'(cfg_cca == 3'h2 || cfg_cca == 3'h5));
		end
	endtask
	task automatic sync(input logic [4:0] t, input int hold, input int lo, input int hi);
		int n;
		n = 0;
		barrier_type = t;
		issue(WSB_OP_SYNC, 32'h0000_0000, 16'h0000);
		chk(32'(barrier_busy), 32'h0000_0001);
		while (op_ready !== 1'b1) begin
			if (n == hold) begin
				load_pending = 1'b0;
				ginv_pending = 1'b0;
			end
			tick(n);
		end
		chk(32'(n >= lo && n <= hi), 32'h0000_0001);
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{op_valid, release6, misalign_support, load_pending, ginv_pending} = '0;
		{kernel_mode, segment_mode_ok, enhanced_addressing_flag} = 3'h7;
		{cop_usable, float_present, cop_two_present} = 3'h7;
		{base_value, source_value, displacement, barrier_type} = '0;
		op_kind = WSB_OP_NONE;
		global_invalidate_support_field = 2'h0;
		cfg_cca = 3'h5;
		cfg_flt = 5'h00;
		repeat (3) @(negedge clock);
		rst = 1'b0;
		store(WSB_OP_WORD, 32'h0000_1008, 16'hFFFC, 32'h0000_1004, WSB_EXC_NONE);
		store(WSB_OP_WORD, 32'h0000_1002, 16'h0000, 32'h0, WSB_EXC_ADEL);
		store(WSB_OP_FLOAT, 32'h0000_2002, 16'h0000, 32'h0, WSB_EXC_ADEL);
		store(WSB_OP_FLOAT, 32'h0000_2000, 16'h0010, 32'h0000_2010, WSB_EXC_NONE);
		store(WSB_OP_COPROCESSOR_TWO, 32'h0000_3000, 16'h8000, 32'hFFFF_B000, WSB_EXC_NONE);
		release6 = 1'b1;
		store(WSB_OP_COPROCESSOR_TWO, 32'h0000_3000, 16'h07FC, 32'h0000_2FFC, WSB_EXC_NONE);
		store(WSB_OP_WORD, 32'h0000_1001, 16'h0000, 32'h0, WSB_EXC_ADEL);
		misalign_support = 1'b1;
		store(WSB_OP_WORD, 32'h0000_1001, 16'h0000, 32'h0000_1001, WSB_EXC_NONE);
		{release6, misalign_support} = 2'h0;
		$display("test plain stores done");
		store(WSB_OP_USER, 32'h0000_4000, 16'h01FC, 32'h0000_3FFC, WSB_EXC_NONE);
		kernel_mode = 1'b0;
		store(WSB_OP_USER, 32'h0000_4000, 16'h0000, 32'h0, WSB_EXC_CPU);
		{kernel_mode, segment_mode_ok} = 2'h2;
		store(WSB_OP_USER, 32'h0000_4000, 16'h0000, 32'h0, WSB_EXC_CPU);
		{segment_mode_ok, enhanced_addressing_flag} = 2'h2;
		store(WSB_OP_USER, 32'h0000_4000, 16'h0000, 32'h0, WSB_EXC_RI);
		{enhanced_addressing_flag, float_present} = 2'h2;
		store(WSB_OP_FLOAT, 32'h0000_4000, 16'h0000, 32'h0, WSB_EXC_RI);
		{float_present, cop_usable} = 2'h2;
		store(WSB_OP_FLOAT, 32'h0000_4000, 16'h0000, 32'h0, WSB_EXC_CPU);
		{cop_usable, cop_two_present} = 2'h2;
		store(WSB_OP_COPROCESSOR_TWO, 32'h0000_4000, 16'h0000, 32'h0, WSB_EXC_RI);
		cop_two_present = 1'b1;
		$display("test gating done");
		for (int i = 0; i < 4; i++) begin
			cfg_flt = 5'(1 << i);
			store(WSB_OP_WORD, 32'h0000_5000, 16'h0000, 32'h0, tlb_codes[i]);
			store(WSB_OP_FLOAT, 32'h0000_5000, 16'h0000, 32'h0, tlb_codes[i]);
		end
		cfg_flt = 5'h10;
		store(WSB_OP_WORD, 32'h0000_5000, 16'h0000, 32'h0000_5000, WSB_EXC_NONE);
		store(WSB_OP_USER, 32'h0000_5000, 16'h0000, 32'h0, WSB_EXC_BUS);
		cfg_flt = 5'h00;
		$display("test translation faults done");
		store(WSB_OP_WORD, 32'h0000_6000, 16'h0000, 32'h0000_6000, WSB_EXC_NONE);
		sync(5'h00, -1, 5, 16);
		cfg_cca = 3'h2;
		store(WSB_OP_WORD, 32'h0000_6004, 16'h0000, 32'h0000_6004, WSB_EXC_NONE);
		sync(5'h05, -1, 5, 16);
		cfg_cca = 3'h3;
		store(WSB_OP_WORD, 32'h0000_6008, 16'h0000, 32'h0000_6008, WSB_EXC_NONE);
		sync(5'h00, -1, 0, 4);
		load_pending = 1'b1;
		sync(5'h00, 8, 8, 12);
		{release6, ginv_pending} = 2'h3;
		global_invalidate_support_field = 2'h2;
		sync(5'h14, 8, 8, 12);
		ginv_pending = 1'b1;
		global_invalidate_support_field = 2'h0;
		sync(5'h14, 8, 0, 4);
		global_invalidate_support_field = 2'h3;
		sync(5'h14, 8, 8, 12);
		{release6, ginv_pending} = 2'h1;
		sync(5'h14, 8, 0, 4);
		$display("test barrier done");
		wrap_up();
	end
endmodule
`default_nettype wire
